/* File: inc/pwm_aux_pkg.sv */
// package: register map, field layout and carriers of the modulator auxiliary block
package pwm_aux_pkg;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_PIN_LEVEL_SAMPLE  = 12'hF26;
  localparam logic [11:0] IDX_OUTPUT_OFF_OVR    = 12'hF27;
  localparam logic [11:0] IDX_MAIN_CONTROL      = 12'hF30;
  localparam logic [11:0] IDX_CONV_TRIGGER      = 12'hF29;
  localparam int          ADDR_W                = 14;
  localparam logic [13:0] ADDR_PIN_LEVEL_SAMPLE = {IDX_PIN_LEVEL_SAMPLE, 2'b00};
  localparam logic [13:0] ADDR_OUTPUT_OFF_OVR   = {IDX_OUTPUT_OFF_OVR, 2'b00};
  localparam logic [13:0] ADDR_MAIN_CONTROL     = {IDX_MAIN_CONTROL, 2'b00};
  localparam logic [13:0] ADDR_CONV_TRIGGER     = {IDX_CONV_TRIGGER, 2'b00};

  // reset values
  localparam logic [7:0] RST_OUTPUT_OFF_OVR = 8'h00;
  localparam logic [7:0] RST_CONV_TRIGGER   = 8'h00;
  localparam logic [7:0] RST_MAIN_CONTROL   = 8'h00;

  // field positions
  localparam int SAMPLE_FAULT_BIT   = 6;
  localparam int OVR_WRITE_MASK_W   = 6;
  localparam int MAIN_GATE_EN_BIT   = 0;
  localparam int TRIG_POLARITY_BIT  = 7;
  localparam int TRIG_HIGH_ACT_BIT  = 6;
  localparam int TRIG_HIGH_INACT_BIT = 5;
  localparam int TRIG_LOW_ACT_BIT   = 4;
  localparam int TRIG_LOW_INACT_BIT = 3;
  localparam int TRIG_CH_USE_W      = 3;

  // one three-phase set of modulator levels
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } phase_set_t;

  // per-pin off-state levels chosen elsewhere
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } off_level_t;

endpackage

/* File: hw/pwm_aux_gate.sv */
// module: pin sampling, output override gate and conversion trigger match
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
// Overview of operation
// - sample register bits 5:0 read six pins
// - sample bit 6 reads fault pin level
// - odd override bits force low side off
// - even override bits force high side off
// - overrides act only with gate enable set
// - modulator keeps running while pins overridden
// - fault forces all six outputs off
// - trigger is polarity XOR OR of terms
// - bit 6 adds all-high-active term
// - bit 5 adds all-high-inactive term
// - bit 4 adds all-low-active term
// - bit 3 adds all-low-inactive term
// - unused channel counts true in terms
// - trigger settings never change output pins
// - conversion starts on trigger rising edge
module pwm_aux_gate
(
  input  wire logic                            core_clk,
  input  wire logic                            resetn,
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [pwm_aux_pkg::ADDR_W-1:0]  wb_adr_i,
  input  wire logic [31:0]                     wb_dat_i,
  input  wire logic [3:0]                      wb_sel_i,
  output logic      [31:0]                     wb_dat_o,
  output logic                                 wb_ack_o,
  output logic                                 wb_err_o,
  input  wire pwm_aux_pkg::phase_set_t         mod_wave,
  input  wire pwm_aux_pkg::off_level_t         off_level,
  input  wire logic                            fault_pin,
  input  wire logic                            fault_active,
  output pwm_aux_pkg::phase_set_t              pwm_out,
  output logic                                 conversion_start
);

  // ****************************************
  // registers and synchronisers
  // ****************************************
  logic [5:0] output_off_override_reg;
  logic [5:0] output_off_override_next;
  logic [7:0] conversion_trigger_match_reg;
  logic [7:0] conversion_trigger_match_next;
  logic       override_gate_enable_reg;
  logic       override_gate_enable_next;
  logic [6:0] pin_meta_reg;
  logic [6:0] pin_sync_reg;
  logic       match_meta_reg;
  logic       match_sync_reg;
  logic       match_prev_reg;

  // ****************************************
  // bus decode
  // ****************************************
  wire        req        = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire        hit_sample = (wb_adr_i == pwm_aux_pkg::ADDR_PIN_LEVEL_SAMPLE);
  wire        hit_ovr    = (wb_adr_i == pwm_aux_pkg::ADDR_OUTPUT_OFF_OVR);
  wire        hit_main   = (wb_adr_i == pwm_aux_pkg::ADDR_MAIN_CONTROL);
  wire        hit_trig   = (wb_adr_i == pwm_aux_pkg::ADDR_CONV_TRIGGER);
  wire        hit_any    = hit_sample | hit_ovr | hit_main | hit_trig;
  wire        wr_lane0   = req & wb_we_i & wb_sel_i[0];

  // pin and fault levels for read
  wire [7:0]  sample_view = {1'b0, pin_sync_reg};

  wire [7:0]  read_mux =
    hit_sample ? sample_view :
    hit_ovr    ? {2'b00, output_off_override_reg} :
    hit_main   ? {7'h00, override_gate_enable_reg} :
    hit_trig   ? conversion_trigger_match_reg : 8'h00;

  // reserved override bits stay zero
  assign output_off_override_next = (wr_lane0 & hit_ovr) ?
    wb_dat_i[pwm_aux_pkg::OVR_WRITE_MASK_W-1:0] : output_off_override_reg;
  assign conversion_trigger_match_next = (wr_lane0 & hit_trig) ?
    wb_dat_i[7:0] : conversion_trigger_match_reg;
  assign override_gate_enable_next = (wr_lane0 & hit_main) ?
    wb_dat_i[pwm_aux_pkg::MAIN_GATE_EN_BIT] : override_gate_enable_reg;

  // ****************************************
  // output gate
  // ****************************************
  // per-pin force off
  wire [2:0] force_low  = override_gate_enable_reg ?
    {output_off_override_reg[5], output_off_override_reg[3], output_off_override_reg[1]} : 3'h0;
  wire [2:0] force_high = override_gate_enable_reg ?
    {output_off_override_reg[4], output_off_override_reg[2], output_off_override_reg[0]} : 3'h0;

  // fault overrides, per-pin forces apply otherwise; waveform passes where not forced
  wire [2:0] gate_high = (fault_active ? 3'h7 : force_high);
  wire [2:0] gate_low  = (fault_active ? 3'h7 : force_low);
  wire [2:0] next_high = (gate_high & off_level.high) | (~gate_high & mod_wave.high);
  wire [2:0] next_low  = (gate_low & off_level.low) | (~gate_low & mod_wave.low);

  // ****************************************
  // trigger match
  // ****************************************
  // unused channel counts true
  function automatic logic all_true(input logic [2:0] lv, input logic [2:0] use_ch);
    all_true = &(lv | ~use_ch);
  endfunction

  wire [2:0] ch_use = conversion_trigger_match_reg[pwm_aux_pkg::TRIG_CH_USE_W-1:0];
  wire [2:0] hi_lv  = pwm_out.high;
  wire [2:0] lo_lv  = pwm_out.low;

  wire t_ha = conversion_trigger_match_reg[pwm_aux_pkg::TRIG_HIGH_ACT_BIT]
            & all_true(hi_lv, ch_use);
  wire t_hi = conversion_trigger_match_reg[pwm_aux_pkg::TRIG_HIGH_INACT_BIT]
            & all_true(~hi_lv, ch_use);
  wire t_la = conversion_trigger_match_reg[pwm_aux_pkg::TRIG_LOW_ACT_BIT]
            & all_true(lo_lv, ch_use);
  wire t_li = conversion_trigger_match_reg[pwm_aux_pkg::TRIG_LOW_INACT_BIT]
            & all_true(~lo_lv, ch_use);
  wire conversion_start_match = conversion_trigger_match_reg[pwm_aux_pkg::TRIG_POLARITY_BIT]
                              ^ (t_ha | t_hi | t_la | t_li);

  // ****************************************
  // clocked state
  // ****************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      output_off_override_reg      <= pwm_aux_pkg::RST_OUTPUT_OFF_OVR[5:0];
      conversion_trigger_match_reg <= pwm_aux_pkg::RST_CONV_TRIGGER;
      override_gate_enable_reg     <= pwm_aux_pkg::RST_MAIN_CONTROL[0];
      wb_ack_o                     <= 1'b0;
      wb_err_o                     <= 1'b0;
      wb_dat_o                     <= 32'h0000_0000;
    end
    else
    begin
      output_off_override_reg      <= output_off_override_next;
      conversion_trigger_match_reg <= conversion_trigger_match_next;
      override_gate_enable_reg     <= override_gate_enable_next;
      wb_ack_o                     <= req & hit_any;
      wb_err_o                     <= req & ~hit_any;
      wb_dat_o                     <= (req & ~wb_we_i) ? {24'h00_0000, read_mux} : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_meta_reg   <= 7'h00;
      pin_sync_reg   <= 7'h00;
      match_meta_reg <= 1'b0;
      match_sync_reg <= 1'b0;
      match_prev_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg   <= {fault_pin, pwm_out.high[2], pwm_out.low[2], pwm_out.high[1],
                         pwm_out.low[1], pwm_out.high[0], pwm_out.low[0]};
      pin_sync_reg   <= pin_meta_reg;
      match_meta_reg <= conversion_start_match;
      match_sync_reg <= match_meta_reg;
      match_prev_reg <= match_sync_reg;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      conversion_start <= 1'b0;
      pwm_out          <= '0;
    end
    else
    begin
      conversion_start <= match_sync_reg & ~match_prev_reg;
      pwm_out          <= '{high: next_high, low: next_low};
    end
  end

endmodule

/* File: sim/pwm_aux_gate_sva.sv */
// checker: bus timing, fault forcing, sampling and trigger pulse properties
`timescale 1ns/1ps
module pwm_aux_gate_sva
(
  input wire logic                       core_clk,
  input wire logic                       resetn,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_we_i,
  input wire logic [13:0]                wb_adr_i,
  input wire logic [31:0]                wb_dat_o,
  input wire logic                       wb_ack_o,
  input wire logic                       wb_err_o,
  input wire pwm_aux_pkg::off_level_t    off_level,
  input wire logic                       fault_pin,
  input wire logic                       fault_active,
  input wire pwm_aux_pkg::phase_set_t    pwm_out,
  input wire logic                       conversion_start
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire mapped = wb_adr_i inside {pwm_aux_pkg::ADDR_PIN_LEVEL_SAMPLE,
    pwm_aux_pkg::ADDR_OUTPUT_OFF_OVR, pwm_aux_pkg::ADDR_MAIN_CONTROL,
    pwm_aux_pkg::ADDR_CONV_TRIGGER};
  wire rd_sample = req & ~wb_we_i & (wb_adr_i == pwm_aux_pkg::ADDR_PIN_LEVEL_SAMPLE);
  chk_ack_next: assert property (req && mapped |=> wb_ack_o && !wb_err_o)
    else $error("ack missing after mapped request");
  chk_err_unmapped: assert property (req && !mapped |=> wb_err_o && !wb_ack_o)
    else $error("err missing after unmapped request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_dat_upper: assert property (wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_fault_force: assert property (fault_active |=> pwm_out == $past(off_level))
    else $error("fault did not force off level");
  chk_conv_pulse: assert property (conversion_start |=> !conversion_start)
    else $error("start pulse longer than one cycle");
  chk_fault_sample: assert property ($stable(fault_pin)[*4] ##0 rd_sample |=>
    wb_dat_o[6] == fault_pin)
    else $error("sampled fault level wrong");
  cov_conv: cover property (conversion_start);
  cov_fault: cover property (fault_active ##1 fault_active);
  cov_err: cover property (wb_err_o);
endmodule

/* File: sim/pwm_aux_adc_model.sv */
// model: conversion unit counting start pulses from the block
`timescale 1ns/1ps
module pwm_aux_adc_model
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic conversion_start,
  output int        n_conv
);
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      n_conv <= 0;
    else if (conversion_start)
      n_conv <= n_conv + 1;
endmodule

/* File: sim/pwm_aux_gate_tb.sv */
// testbench: registers, overrides, fault forcing and conversion starts
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", n, e, s); end end
module pwm_aux_gate_tb;
  logic core_clk = 0, resetn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, e;
  logic fault_pin = 0, fault_active = 0, wb_ack_o, wb_err_o, conversion_start;
  logic [13:0] wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic [3:0]  wb_sel_i = 4'hF;
  pwm_aux_pkg::phase_set_t mod_wave = 0, pwm_out;
  pwm_aux_pkg::off_level_t off_level = 0;
  int n_mismatch = 0, tests_run = 0, n_conv;
  always #10 core_clk = ~core_clk;
  pwm_aux_gate u_dut (.core_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .mod_wave, .off_level,
    .fault_pin, .fault_active, .pwm_out, .conversion_start);
  pwm_aux_adc_model u_adc (.core_clk, .resetn, .conversion_start, .n_conv);
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic bus(input logic we, input logic [13:0] a, input logic [7:0] d);
    int k;
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1 && k < 20);
    q = wb_dat_o;
    e = wb_err_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (k >= 20)
    begin
      n_mismatch++;
      final_report();
    end
  endtask
  task automatic t_regs;
    bus(0, pwm_aux_pkg::ADDR_OUTPUT_OFF_OVR, 0);
    `CHK("override reset", 32'h0, q)
    bus(1, pwm_aux_pkg::ADDR_OUTPUT_OFF_OVR, 8'h3F);
    bus(0, pwm_aux_pkg::ADDR_OUTPUT_OFF_OVR, 0);
    `CHK("override bits", 32'h3F, q)
    bus(1, pwm_aux_pkg::ADDR_CONV_TRIGGER, 8'hFF);
    bus(0, pwm_aux_pkg::ADDR_CONV_TRIGGER, 0);
    `CHK("trigger bits", 32'hFF, q)
    wb_sel_i <= 4'hE;
    bus(1, pwm_aux_pkg::ADDR_CONV_TRIGGER, 8'h00);
    wb_sel_i <= 4'hF;
    bus(0, pwm_aux_pkg::ADDR_CONV_TRIGGER, 0);
    `CHK("lane off write", 32'hFF, q)
    bus(0, 14'h0004, 0);
    `CHK("unmapped err", 1'h1, e)
  endtask
  task automatic t_override;
    logic [5:0] x;
    mod_wave <= 6'h3F;
    fault_pin <= 1'h1;
    bus(1, pwm_aux_pkg::ADDR_MAIN_CONTROL, 0);
    repeat (2) @(posedge core_clk);
    `CHK("gate off", 6'h3F, pwm_out)
    bus(1, pwm_aux_pkg::ADDR_MAIN_CONTROL, 8'h01);
    for (int i = 0; i < 6; i++)
    begin
      bus(1, pwm_aux_pkg::ADDR_OUTPUT_OFF_OVR, 8'h01 << i);
      repeat (4) @(posedge core_clk);
      x = 6'h3F;
      x[i[0] ? i / 2 : 3 + i / 2] = 1'h0;
      `CHK("forced pin", x, pwm_out)
      bus(0, pwm_aux_pkg::ADDR_PIN_LEVEL_SAMPLE, 0);
      `CHK("sample", {2'h1, x[5], x[2], x[4], x[1], x[3], x[0]}, q[7:0])
    end
  endtask
  task automatic t_fault;
    off_level <= 6'h2A;
    fault_active <= 1'h1;
    repeat (3) @(posedge core_clk);
    `CHK("fault force", 6'h2A, pwm_out)
    fault_active <= 1'h0;
    bus(1, pwm_aux_pkg::ADDR_OUTPUT_OFF_OVR, 0);
    repeat (3) @(posedge core_clk);
    `CHK("fault release", 6'h3F, pwm_out)
  endtask
  task automatic t_trigger;
    logic [7:0] cfg[6] = '{8'h47, 8'h27, 8'h17, 8'h0F, 8'hC7, 8'h40};
    logic [5:0] wa[6] = '{6'h00, 6'h38, 6'h00, 6'h07, 6'h38, 6'h00};
    logic [5:0] wz[6] = '{6'h38, 6'h00, 6'h07, 6'h00, 6'h00, 6'h38};
    int c;
    for (int i = 0; i < 6; i++)
    begin
      mod_wave <= wa[i];
      bus(1, pwm_aux_pkg::ADDR_CONV_TRIGGER, cfg[i]);
      repeat (6) @(posedge core_clk);
      c = n_conv;
      mod_wave <= wz[i];
      repeat (6) @(posedge core_clk);
      `CHK("pins untouched", wz[i], pwm_out)
      mod_wave <= wa[i];
      repeat (6) @(posedge core_clk);
      `CHK("start count", (i == 5) ? 0 : 1, n_conv - c)
    end
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'h1;
    t_regs();
    t_override();
    t_fault();
    t_trigger();
    final_report();
  end
endmodule
bind pwm_aux_gate pwm_aux_gate_sva u_sva (.core_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .off_level, .fault_pin, .fault_active,
  .pwm_out, .conversion_start);
